// >>> hdl/dbfc_consts.svh
// Constants for the dual bank flash controller
// Notes on behaviour
// - Two banks, primary and secondary, each reads 32-bit wide bursts to the processor.
// - One bank reads while the other bank programs or erases.
// - Each program operation writes exactly one 16-bit half-word supplied by the requester.
// - Erase covers either one sector or the whole bank array.
// - Primary sectors are 64 KB; 4, 8, 16 or 32 of them.
// - Boot code comes only from flash, from the bank the stored selection names.
// - Only the JTAG channel may change the stored boot selection.
// - JTAG can program both banks with no processor involvement.
`ifndef DBFC_CONSTS_SVH
`define DBFC_CONSTS_SVH
`define DBFC_SECTOR_BYTES    65536
`define DBFC_SECTOR_AW       16
`define DBFC_PRI_SECTORS     4
`define DBFC_SEC_SECTORS     4
`define DBFC_PROG_CYCLES     4
`define DBFC_SECT_ERASE_CYC  16
`define DBFC_ARRAY_ERASE_CYC 64
`define DBFC_BOOT_RESET      1'b0
`endif

// >>> hdl/dbfc_pkg.sv
// Types for the dual bank flash controller
`default_nettype none
package dbfc_pkg;
  typedef enum logic [1:0] {DBFC_OP_PROG, DBFC_OP_SECT_ERASE, DBFC_OP_ARRAY_ERASE, DBFC_OP_NONE} dbfc_op_e;
  typedef enum logic [1:0] {DBFC_IDLE, DBFC_WORK, DBFC_DONE} dbfc_state_e;
endpackage : dbfc_pkg
`default_nettype wire

// >>> hdl/dbfc_bank.sv
// One flash bank: array, sequencer for program and erase, registered burst read
`timescale 1ns/1ns
`default_nettype none
`include "dbfc_consts.svh"
module dbfc_bank #(
  parameter int AW      = 10,
  parameter int SECTORS = 4,
  parameter int SAW     = 8
) (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rst_b,
  // Read port
  input  wire logic               rd_en,
  input  wire logic [AW-1:0]      rd_addr,
  output logic [31:0]             rd_data,
  // Operation port, taken only when not busy
  input  wire logic               op_start,
  input  wire dbfc_pkg::dbfc_op_e op_kind,
  input  wire logic [AW:0]        op_haddr,
  input  wire logic [15:0]        op_data,
  output logic                    busy,
  output logic                    done
);
  import dbfc_pkg::*;
  localparam int WORDS = 1 << AW;
  localparam int SPW   = WORDS / SECTORS;
  logic [31:0]   mem [WORDS];
  dbfc_state_e   st_q, st_d;
  dbfc_op_e      kind_q, kind_d;
  logic [AW:0]   addr_q, addr_d;
  logic [15:0]   data_q, data_d;
  logic [7:0]    cnt_q, cnt_d;
  logic [31:0]   rd_q;
  logic          wr_prog, wr_erase;

  function automatic logic in_sector(input logic [AW-1:0] w, input logic [AW:0] h);
    in_sector = (int'(w) / SPW) == (int'(h[AW:1]) / SPW);
  endfunction : in_sector

  always_comb begin
    st_d = st_q; kind_d = kind_q; addr_d = addr_q; data_d = data_q; cnt_d = cnt_q;
    wr_prog = 1'b0; wr_erase = 1'b0;
    case (st_q)
      DBFC_IDLE: begin
        if (op_start) begin
          st_d = DBFC_WORK; kind_d = op_kind; addr_d = op_haddr; data_d = op_data;
          cnt_d = (op_kind == DBFC_OP_PROG) ? 8'(`DBFC_PROG_CYCLES) :
                  (op_kind == DBFC_OP_SECT_ERASE) ? 8'(`DBFC_SECT_ERASE_CYC) : 8'(`DBFC_ARRAY_ERASE_CYC);
        end
      end
      DBFC_WORK: begin
        if (cnt_q <= 8'h01) begin
          st_d = DBFC_DONE;
          wr_prog  = (kind_q == DBFC_OP_PROG);
          // An unused operation code runs its time out but touches no word
          wr_erase = (kind_q == DBFC_OP_SECT_ERASE) || (kind_q == DBFC_OP_ARRAY_ERASE);
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      default: st_d = DBFC_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= DBFC_IDLE; kind_q <= DBFC_OP_NONE; addr_q <= '0; data_q <= 16'h0000; cnt_q <= 8'h00;
    end else begin
      st_q <= st_d; kind_q <= kind_d; addr_q <= addr_d; data_q <= data_d; cnt_q <= cnt_d;
    end
  end

  // Program only clears bits, as real flash does; erase sets to all ones
  always_ff @(posedge clock) begin
    for (int i = 0; i < WORDS; i++) begin
      if (wr_erase && (kind_q == DBFC_OP_ARRAY_ERASE || in_sector(AW'(i), addr_q)))
        mem[i] <= 32'hFFFFFFFF;
    end
    if (wr_prog) begin
      if (addr_q[0]) mem[addr_q[AW:1]][31:16] <= mem[addr_q[AW:1]][31:16] & data_q;
      else           mem[addr_q[AW:1]][15:0]  <= mem[addr_q[AW:1]][15:0]  & data_q;
    end
    if (rd_en) rd_q <= mem[rd_addr];
  end

  assign rd_data = rd_q;
  assign busy    = (st_q == DBFC_WORK);
  assign done    = (st_q == DBFC_DONE);
endmodule : dbfc_bank
`default_nettype wire

// >>> hdl/dbfc_top.sv
// Dual bank flash controller: bus reads, program and erase, JTAG path, boot bank select
`timescale 1ns/1ns
`default_nettype none
`include "dbfc_consts.svh"
module dbfc_top #(
  parameter int PAW = 10,
  parameter int SAW = 8,
  parameter int PRI_SECTORS = `DBFC_PRI_SECTORS,
  parameter int SEC_SECTORS = `DBFC_SEC_SECTORS
) (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rst_b,
  // Processor read port: bank select, word address, one word per cycle
  input  wire logic               cpu_rd,
  input  wire logic               cpu_rd_bank,
  input  wire logic [PAW-1:0]     cpu_rd_addr,
  output logic [31:0]             cpu_rd_data,
  output logic                    cpu_rd_valid,
  // Processor operation port
  input  wire logic               cpu_op,
  input  wire logic               cpu_op_bank,
  input  wire dbfc_pkg::dbfc_op_e cpu_op_kind,
  input  wire logic [PAW:0]       cpu_op_haddr,
  input  wire logic [15:0]        cpu_op_data,
  output logic                    cpu_op_ack,
  // JTAG operation port, wins over the processor on the same bank
  input  wire logic               jtag_op,
  input  wire logic               jtag_op_bank,
  input  wire dbfc_pkg::dbfc_op_e jtag_op_kind,
  input  wire logic [PAW:0]       jtag_op_haddr,
  input  wire logic [15:0]        jtag_op_data,
  output logic                    jtag_op_ack,
  input  wire logic               jtag_boot_wr,
  input  wire logic               jtag_boot_val,
  // Status
  output logic [1:0]              bank_busy,
  output logic                    boot_bank,
  output logic [1:0]              op_done
);
  import dbfc_pkg::*;
  logic [1:0]  busy_w, done_w, start_w;
  logic [31:0] rdata_w [2];
  dbfc_op_e    kind_w [2];
  logic [PAW:0] haddr_w [2];
  logic [15:0] data_w [2];
  logic        boot_q, boot_d, cpu_ack_q, cpu_ack_d, jtag_ack_q, jtag_ack_d;
  logic        rv_q, rbank_q;
  logic [31:0] rd_q;
  logic [1:0]  busy_q, done_q;

  // Boot select is reset to DBFC_BOOT_RESET by rst_b; only JTAG writes reach it
  always_comb begin
    boot_d = jtag_boot_wr ? jtag_boot_val : boot_q;
  end

  always_comb begin
    cpu_ack_d = 1'b0; jtag_ack_d = 1'b0;
    for (int b = 0; b < 2; b++) begin
      start_w[b] = 1'b0; kind_w[b] = DBFC_OP_NONE; haddr_w[b] = '0; data_w[b] = 16'h0000;
      if (jtag_op && jtag_op_bank == b[0] && !busy_w[b] && !done_w[b]) begin
        start_w[b] = 1'b1; kind_w[b] = jtag_op_kind; haddr_w[b] = jtag_op_haddr; data_w[b] = jtag_op_data;
        jtag_ack_d = 1'b1;
      end else if (cpu_op && cpu_op_bank == b[0] && !busy_w[b] && !done_w[b]) begin
        start_w[b] = 1'b1; kind_w[b] = cpu_op_kind; haddr_w[b] = cpu_op_haddr; data_w[b] = cpu_op_data;
        cpu_ack_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      boot_q <= `DBFC_BOOT_RESET; cpu_ack_q <= 1'b0; jtag_ack_q <= 1'b0;
      rv_q <= 1'b0; rbank_q <= 1'b0; busy_q <= 2'h0; done_q <= 2'h0; rd_q <= 32'h00000000;
    end else begin
      boot_q <= boot_d; cpu_ack_q <= cpu_ack_d; jtag_ack_q <= jtag_ack_d;
      rv_q <= cpu_rd; rbank_q <= cpu_rd_bank;
      busy_q <= busy_w | start_w; done_q <= done_w;
      if (rv_q) rd_q <= rdata_w[rbank_q];
    end
  end

  // Banks are independent, so a read of one runs during an operation on the other
  for (genvar g = 0; g < 2; g++) begin : g_bank
    dbfc_bank #(
      .AW      (g == 0 ? PAW : SAW),
      .SECTORS (g == 0 ? PRI_SECTORS : SEC_SECTORS),
      .SAW     (SAW)
    ) u_bank (
      .clock    (clock),
      .rst_b    (rst_b),
      .rd_en    (cpu_rd && cpu_rd_bank == g[0]),
      .rd_addr  (cpu_rd_addr[(g == 0 ? PAW : SAW)-1:0]),
      .rd_data  (rdata_w[g]),
      .op_start (start_w[g]),
      .op_kind  (kind_w[g]),
      .op_haddr (haddr_w[g][(g == 0 ? PAW : SAW):0]),
      .op_data  (data_w[g]),
      .busy     (busy_w[g]),
      .done     (done_w[g])
    );
  end

  assign cpu_rd_data  = rd_q;
  assign cpu_rd_valid = rv_q;
  assign cpu_op_ack   = cpu_ack_q;
  assign jtag_op_ack  = jtag_ack_q;
  assign bank_busy    = busy_q;
  assign boot_bank    = boot_q;
  assign op_done      = done_q;
endmodule : dbfc_top
`default_nettype wire

// >>> test/dbfc_monitor.sv
// Port checker for the dual bank flash controller
`timescale 1ns/1ns
`default_nettype none
module dbfc_monitor (
  // Clock, reset, reads
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic       cpu_rd,
  input wire logic       cpu_rd_bank,
  input wire logic       cpu_rd_valid,
  // Operations and boot selection
  input wire logic       cpu_op,
  input wire logic       cpu_op_bank,
  input wire logic       cpu_op_ack,
  input wire logic       jtag_op,
  input wire logic       jtag_op_ack,
  input wire logic       jtag_boot_wr,
  input wire logic       jtag_boot_val,
  input wire logic       boot_bank,
  // Status
  input wire logic [1:0] bank_busy,
  input wire logic [1:0] op_done
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_rd_answered: assert property (cpu_rd |=> cpu_rd_valid) else $error("read not answered");
  a_rd_busy_bank: assert property (cpu_rd && bank_busy[cpu_rd_bank] |=> cpu_rd_valid) else $error("read stalled");
  a_boot_kept: assert property (!jtag_boot_wr |=> $stable(boot_bank)) else $error("boot bank moved");
  a_boot_written: assert property (jtag_boot_wr |=> boot_bank == $past(jtag_boot_val)) else $error("boot lost");
  a_ack_cause: assert property (cpu_op_ack |-> $past(cpu_op)) else $error("ack without request");
  a_jtag_ack_cause: assert property (jtag_op_ack |-> $past(jtag_op)) else $error("jtag ack alone");
  a_busy_refuse: assert property (cpu_op && bank_busy[cpu_op_bank] |=> !cpu_op_ack) else $error("busy taken");
  // Registered busy and done both low means the bank sequencer sits idle
  a_idle_taken: assert property (cpu_op && !jtag_op && !bank_busy[cpu_op_bank] && !op_done[cpu_op_bank]
                                 |=> cpu_op_ack) else $error("idle bank refused");
  a_busy_min: assert property ($rose(bank_busy[0]) |-> bank_busy[0] [*4]) else $error("busy too short");
  a_done_early: assert property ($rose(bank_busy[1]) |-> !op_done[1] [*4]) else $error("done too early");
  c_cpu_ack: cover property (cpu_op_ack);
  c_jtag_ack: cover property (jtag_op_ack);
  c_done_sec: cover property (op_done[1]);
endmodule : dbfc_monitor
bind dbfc_top dbfc_monitor u_mon (.*);
`default_nettype wire

// >>> test/dbfc_jtag_host.sv
// Behavioural JTAG programming channel on the operation port
`timescale 1ns/1ns
`default_nettype none
module dbfc_jtag_host (
  // Clock and answer
  input wire logic           clock,
  input wire logic           ack,
  // Request
  output logic               op,
  output logic               bank,
  output dbfc_pkg::dbfc_op_e kind,
  output logic [10:0]        haddr,
  output logic [15:0]        data
);
  import dbfc_pkg::*;
  initial begin
    op = 0; bank = 0; kind = DBFC_OP_NONE; haddr = '0; data = '0;
  end
  // One whole half-word per request, held until acknowledged
  task automatic req(input logic b, input dbfc_op_e k, input logic [10:0] a, input logic [15:0] d);
    @(negedge clock);
    op = 1; bank = b; kind = k; haddr = a; data = d;
    do @(posedge clock); while (!ack);
    @(negedge clock);
    op = 0; haddr = ~a; data = ~d; // Released address and data lines must not keep the last value
  endtask : req
endmodule : dbfc_jtag_host
`default_nettype wire

// >>> test/dbfc_top_tb.sv
// Self-checking bench of the dual bank flash controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin fails++; $display("mismatch %s %h %h", n, e, a); end end
module dbfc_top_tb;
  import dbfc_pkg::*;
  logic clock = 0, rst_b = 0, cpu_rd = 0, cpu_rd_bank = 0, cpu_op = 0, cpu_op_bank = 0, jtag_boot_wr = 0;
  logic jtag_boot_val = 0, cpu_rd_valid, cpu_op_ack, jtag_op, jtag_op_bank, jtag_op_ack, boot_bank;
  logic [9:0] cpu_rd_addr = '0;
  logic [10:0] cpu_op_haddr = '0, jtag_op_haddr, ha;
  logic [15:0] cpu_op_data = '0, jtag_op_data, hd;
  logic [31:0] cpu_rd_data;
  logic [1:0] bank_busy, op_done;
  dbfc_op_e cpu_op_kind = DBFC_OP_NONE, jtag_op_kind;
  int fails = 0, samples_checked = 0;
  int unsigned m[2][1024];
  always #50 clock = ~clock;
  dbfc_top DUT (.*);
  dbfc_jtag_host jh (.clock, .ack(jtag_op_ack), .op(jtag_op), .bank(jtag_op_bank), .kind(jtag_op_kind),
                     .haddr(jtag_op_haddr), .data(jtag_op_data));
  task automatic rd(input logic b, input logic [9:0] a);
    @(negedge clock);
    cpu_rd = 1; cpu_rd_bank = b; cpu_rd_addr = a;
    @(negedge clock);
    cpu_rd = 0;
    `CHK("valid", 1'b1, cpu_rd_valid)
    @(negedge clock);
    `CHK("data", m[b][b ? a[7:0] : a], cpu_rd_data)
  endtask : rd
  task automatic op(input logic j, b, input dbfc_op_e k, input logic [10:0] a, input logic [15:0] d);
    int n = 0;
    int w = a[10:1] & (b ? 10'hFF : 10'h3FF);
    int s = b ? 64 : 256;
    if (j) jh.req(b, k, a, d);
    else begin
      @(negedge clock);
      cpu_op = 1; cpu_op_bank = b; cpu_op_kind = k; cpu_op_haddr = a; cpu_op_data = d;
      do @(posedge clock); while (!cpu_op_ack && ++n < 200);
      @(negedge clock);
      cpu_op = 0; cpu_op_data = ~d;
    end
    `CHK("busy", 1'b1, bank_busy[b])
    n = 0;
    do @(posedge clock); while (!op_done[b] && ++n < 200);
    `CHK("done", 1'b1, op_done[b])
    case (k)
      DBFC_OP_PROG: m[b][w] &= a[0] ? {d, 16'hFFFF} : {16'hFFFF, d};
      DBFC_OP_SECT_ERASE: for (int i = w / s * s; i < w / s * s + s; i++) m[b][i] = '1;
      default: for (int i = 0; i < 1024; i++) m[b][i] = '1;
    endcase
  endtask : op
  task automatic print_verdict;
    $display("checked %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  initial begin
    #(3000 * 100);
    fails++;
    print_verdict;
  end
  initial begin
    void'($urandom(32'h9367));
    repeat (4) @(negedge clock);
    rst_b = 1;
    `CHK("boot", 1'b0, boot_bank)
    op(1, 0, DBFC_OP_ARRAY_ERASE, 0, 0);
    op(0, 1, DBFC_OP_ARRAY_ERASE, 0, 0);
    for (int i = 0; i < 4; i++) begin
      ha = 11'($urandom);
      hd = 16'($urandom);
      fork
        op(i[0], i[1], DBFC_OP_PROG, ha, hd);
        rd(!i[1], 10'($urandom));
      join
      fork
        op(1, i[1], DBFC_OP_PROG, ha ^ 11'h1, ~hd);
        op(0, i[1], DBFC_OP_PROG, ha, 16'($urandom));
      join
      rd(i[1], ha[10:1]);
    end
    $display("test program done");
    for (int b = 0; b < 2; b++) begin
      ha = 11'($urandom);
      op(0, b[0], DBFC_OP_PROG, ha, 16'h0);
      op(1, b[0], DBFC_OP_SECT_ERASE, ha ^ (b ? 11'h80 : 11'h200), 0);
      rd(b[0], ha[10:1]);
      op(0, b[0], DBFC_OP_SECT_ERASE, ha, 0);
      rd(b[0], ha[10:1]);
    end
    $display("test erase done");
    @(negedge clock);
    jtag_boot_wr = 1; jtag_boot_val = 1;
    @(negedge clock);
    jtag_boot_wr = 0; jtag_boot_val = 0;
    `CHK("boot", 1'b1, boot_bank)
    $display("test boot done");
    print_verdict;
  end
endmodule : dbfc_top_tb
`default_nettype wire
